/* File: pkg/afda_params.svh */
// constants of the flag register, register map and addressing
// assumes: included by bare name from core and bench
`ifndef AFDA_PARAMS_SVH
`define AFDA_PARAMS_SVH
// apb byte offsets
`define AFDA_FLAG_OFS 12'hfd8
`define AFDA_BANK_OFS 12'hfe0
`define AFDA_PTR0_OFS 12'hfe4
`define AFDA_PTR1_OFS 12'hfe8
`define AFDA_PTR2_OFS 12'hfec
`define AFDA_CTRL_OFS 12'hff0
`define AFDA_ACC_OFS 12'hff4
// flag bit positions
`define AFDA_N_BIT 4
`define AFDA_OV_BIT 3
`define AFDA_Z_BIT 2
`define AFDA_DC_BIT 1
`define AFDA_C_BIT 0
// reset values
`define AFDA_FLAG_RST 5'h00
`define AFDA_BANK_RST 4'h0
`define AFDA_PTR_RST 12'h000
`define AFDA_ACC_RST 8'h00
// access bank split and literal offset limit
`define AFDA_ACC_SPLIT 8'h60
`define AFDA_IDX_LIMIT 8'h5f
`define AFDA_SFR_PAGE 4'hf
`define AFDA_LOW_PAGE 4'h0
`endif

/* File: pkg/afda_pkg.sv */
// types shared by the flag and addressing core
// assumes: afda_params.svh holds the numeric constants
package afda_pkg;
  // operation classes the decoder hands over
  typedef enum logic [3:0] {
    K_ADD, K_SUB, K_AND, K_OR, K_XOR, K_ROTR, K_ROTL, K_CLR,
    K_MOVW, K_FILE_TO_FILE_MOVE_OP, K_BITCLR, K_BITSET, K_SWAP, K_JUMP
  } afda_kind_type;

  // operand addressing of a request
  typedef enum logic [1:0] {
    AM_DIRECT, AM_POINTER, AM_FULL
  } afda_amode_type;

  // pointer operand side action
  typedef enum logic [2:0] {
    PA_PLAIN, PA_AFTER_BUMP_UP_OPERAND, PA_AFTER_BUMP_DOWN_OPERAND, PA_BEFORE_BUMP_UP_OPERAND, PA_ACCUM_OFFSET_OPERAND
  } afda_pact_type;

  typedef struct packed {
    afda_kind_type  kind;
    afda_amode_type amode;
    afda_pact_type  pact;
    logic [1:0]     psel;
    logic [7:0]     faddr;
    logic           acc_a;
    logic           has_d;
    logic           dest_d;
    logic           use_lit;
    logic [7:0]     lit;
    logic [11:0]    full;
    logic [19:0]    prog;
  } afda_op_type;

  typedef struct packed {
    logic        valid;
    logic [11:0] addr;
    logic [7:0]  data;
    logic        to_w;
    logic        to_file;
  } afda_res_type;
endpackage : afda_pkg

/* File: rtl/afda_core.sv */
// flag register, alu flag generation and data operand addressing
// assumes: decoder presents one op with its file operand in the
// same cycle; apb master per protocol; single 10 MHz clock
//
// Overview of operation
// - flag register as destination cannot overwrite flags the op itself sets
// - clearing the flag register sets zero only, others unchanged
// - flag bits 7-5 read zero, writes ignored
// - negative flag follows result bit 7
// - signed overflow flag set when sign bit wrongly changes
// - zero flag set when result equals zero
// - half byte carry records carry out of bit 3 on add/sub
// - carry records carry out of bit 7 on add/sub
// - subtract adds two's complement; carries read as inverted borrow
// - rotates load half byte carry from source bit 4 or 3
// - rotates load carry from source bit 0 or 7
// - jump carries a 20-bit program address literal
// - bit and byte ops carry an 8-bit file address
// - access bit one joins bank pick register and file address
// - access bit zero selects access bank, bank pick unused
// - full 12-bit address ops ignore bank pick register
// - dest bit one writes file, zero writes accumulator
// - ops without dest bit use their fixed destination
// - pointers address memory and are directly readable and writable
// - pointer operands post-increment, post-decrement, pre-increment, offset
// - literal offset mode only with extended set enabled
// - pointers hold a 12-bit linear address
// - accumulator offset adds signed accumulator, changes nothing
// - pointer bumps carry across bytes and touch no flag
// - pointer accesses ignore bank pick and access bit
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`include "afda_params.svh"

module afda_core
  import afda_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int NPTR   = 3
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // decoder request
  input  wire logic        op_valid,
  input  wire afda_op_type op,
  input  wire logic [7:0]  mem_rdata,
  // results
  output afda_res_type     res,
  output logic [19:0]      prog_addr,
  output logic             prog_load,
  output logic [ADDR_W-1:0] op_addr
);
  // elaboration-time check
  if (ADDR_W != 12 || NPTR != 3) begin : g_chk
    $error("afda_core supports only a 12-bit space and three pointers");
  end

  localparam logic [11:0] FLAG_OFS = `AFDA_FLAG_OFS;

  // state
  logic [4:0]  flags_q, flags_d;
  logic [3:0]  bank_q, bank_d;
  logic        ext_q, ext_d;
  logic [7:0]  acc_q, acc_d;
  logic [11:0] ptr_q [NPTR];
  logic [31:0] prdata_q, prdata_d;
  afda_res_type res_q, res_d;
  logic [19:0] prog_q;
  logic        pload_q;
  logic [11:0] addr_q;

  // apb decode
  wire logic [11:0] a_ofs   = paddr[11:0];
  wire logic        hit_fl  = a_ofs == `AFDA_FLAG_OFS;
  wire logic        hit_bk  = a_ofs == `AFDA_BANK_OFS;
  wire logic        hit_p0  = a_ofs == `AFDA_PTR0_OFS;
  wire logic        hit_p1  = a_ofs == `AFDA_PTR1_OFS;
  wire logic        hit_p2  = a_ofs == `AFDA_PTR2_OFS;
  wire logic        hit_ct  = a_ofs == `AFDA_CTRL_OFS;
  wire logic        hit_ac  = a_ofs == `AFDA_ACC_OFS;
  wire logic        hit_any = (hit_fl | hit_bk | hit_p0 | hit_p1 | hit_p2 | hit_ct | hit_ac)
                              && paddr[31:12] == 20'h00000;
  wire logic        acc_ph  = psel & penable;
  wire logic        wr_en   = acc_ph & pwrite & hit_any;
  wire logic [NPTR-1:0] hit_p = {hit_p2, hit_p1, hit_p0};

  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = acc_ph & ~hit_any;
  assign prdata  = prdata_q;

  // read data captured in the setup phase, so it comes from a flop
  assign prdata_d = !hit_any ? 32'h0000_0000 :
                    hit_fl ? {27'h0000000, flags_q} :
                    hit_bk ? {28'h0000000, bank_q} :
                    hit_p0 ? {20'h00000, ptr_q[0]} :
                    hit_p1 ? {20'h00000, ptr_q[1]} :
                    hit_p2 ? {20'h00000, ptr_q[2]} :
                    hit_ct ? {31'h00000000, ext_q} :
                    {24'h000000, acc_q};

  // pointer select and pointer-relative address
  wire logic        fire   = op_valid;
  wire logic [11:0] p_cur  = ptr_q[op.psel];
  wire logic [11:0] w_sext = {{4{acc_q[7]}}, acc_q};
  wire logic [11:0] ind_addr =
    op.pact == PA_BEFORE_BUMP_UP_OPERAND ? p_cur + 12'h001 :
    op.pact == PA_ACCUM_OFFSET_OPERAND  ? p_cur + w_sext :
    p_cur;

  // direct address forms
  wire logic idx_mode = ext_q && !op.acc_a && op.faddr <= `AFDA_IDX_LIMIT;
  wire logic [11:0] idx_addr = ptr_q[2] + {4'h0, op.faddr};
  wire logic [11:0] bank_addr = {bank_q, op.faddr};
  wire logic [11:0] accb_addr = op.faddr >= `AFDA_ACC_SPLIT ?
                                {`AFDA_SFR_PAGE, op.faddr} :
                                {`AFDA_LOW_PAGE, op.faddr};
  wire logic [11:0] dir_addr = op.acc_a ? bank_addr : (idx_mode ? idx_addr : accb_addr);

  // final operand address
  wire logic [11:0] tgt_addr =
    op.amode == AM_POINTER ? ind_addr :
    op.amode == AM_FULL    ? op.full :
    dir_addr;

  // file operand; the flag register is served from this block
  wire logic        tgt_fl = tgt_addr == FLAG_OFS;
  wire logic [7:0]  fopnd  = tgt_fl ? {3'h0, flags_q} : mem_rdata;
  wire logic [7:0]  opa    = op.use_lit ? op.lit : fopnd;
  wire logic        is_sub = op.kind == K_SUB;
  wire logic [7:0]  opb    = is_sub ? ~acc_q : acc_q;
  wire logic        cin    = is_sub;

  // adder with half-byte and byte carries
  wire logic [8:0]  sum9   = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
  wire logic [4:0]  half5  = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
  wire logic        ov_add = (opa[7] == opb[7]) && (sum9[7] != opa[7]);

  // result and flag computation per operation
  logic [7:0] alu_res;
  logic [4:0] calc, aff;
  always_comb begin
    alu_res = fopnd;
    calc    = flags_q;
    aff     = 5'h00;
    unique case (op.kind)
      K_ADD, K_SUB: begin
        alu_res = sum9[7:0];
        calc[`AFDA_C_BIT]  = sum9[8];
        calc[`AFDA_DC_BIT] = half5[4];
        calc[`AFDA_OV_BIT] = ov_add;
        aff = 5'h1f;
      end
      K_AND: begin
        alu_res = opa & acc_q;
        aff = 5'h14;
      end
      K_OR: begin
        alu_res = opa | acc_q;
        aff = 5'h14;
      end
      K_XOR: begin
        alu_res = opa ^ acc_q;
        aff = 5'h14;
      end
      K_ROTR: begin
        alu_res = {flags_q[`AFDA_C_BIT], fopnd[7:1]};
        calc[`AFDA_C_BIT]  = fopnd[0];
        calc[`AFDA_DC_BIT] = fopnd[4];
        aff = 5'h17;
      end
      K_ROTL: begin
        alu_res = {fopnd[6:0], flags_q[`AFDA_C_BIT]};
        calc[`AFDA_C_BIT]  = fopnd[7];
        calc[`AFDA_DC_BIT] = fopnd[3];
        aff = 5'h17;
      end
      K_CLR: begin
        alu_res = 8'h00;
        aff = 5'h04;
      end
      K_MOVW:   alu_res = acc_q;
      K_FILE_TO_FILE_MOVE_OP:  alu_res = mem_rdata;
      K_BITCLR: alu_res = fopnd & ~(8'h01 << op.lit[2:0]);
      K_BITSET: alu_res = fopnd | (8'h01 << op.lit[2:0]);
      K_SWAP:   alu_res = {fopnd[3:0], fopnd[7:4]};
      K_JUMP:   alu_res = fopnd;
      default:  alu_res = fopnd; // codes past the last kind
    endcase
    calc[`AFDA_N_BIT] = alu_res[7];
    calc[`AFDA_Z_BIT] = alu_res == 8'h00;
  end

  // destination select
  wire logic to_w  = op.has_d ? !op.dest_d : op.use_lit;
  wire logic is_fw = fire && op.kind != K_JUMP;
  wire logic wr_fl = is_fw && !to_w && tgt_fl;

  // flag next value: apb, then file write, then op-owned bits
  wire logic [4:0] fl_base = wr_en && hit_fl ? pwdata[4:0] : flags_q;
  // an op that owns any flag locks all five against its own file write,
  // so only flag-neutral ops can load the flag register from a result
  wire logic       fl_lock = |aff;
  wire logic [4:0] fl_wr   = wr_fl && !fl_lock ? alu_res[4:0] : fl_base;
  wire logic [4:0] fl_mask = is_fw ? aff : 5'h00;
  assign flags_d = (fl_mask & calc) | (~fl_mask & fl_wr);

  assign bank_d = wr_en && hit_bk ? pwdata[3:0] : bank_q;
  assign ext_d  = wr_en && hit_ct ? pwdata[0] : ext_q;
  assign acc_d  = is_fw && to_w ? alu_res :
                  wr_en && hit_ac ? pwdata[7:0] : acc_q;

  // result record for data memory
  always_comb begin
    res_d         = '0;
    res_d.valid   = is_fw;
    res_d.addr    = tgt_addr;
    res_d.data    = alu_res;
    res_d.to_w    = to_w;
    res_d.to_file = !to_w && !tgt_fl;
  end

  // pointers: apb writes win over bumps; bumps change no flag
  for (genvar i = 0; i < NPTR; i++) begin : g_ptr
    logic [11:0] nxt;
    wire logic   sel = fire && op.amode == AM_POINTER && op.psel == 2'(i);
    assign nxt = wr_en && hit_p[i] ? pwdata[11:0] :
                 sel && op.pact == PA_AFTER_BUMP_UP_OPERAND ? ptr_q[i] + 12'h001 :
                 sel && op.pact == PA_AFTER_BUMP_DOWN_OPERAND ? ptr_q[i] - 12'h001 :
                 sel && op.pact == PA_BEFORE_BUMP_UP_OPERAND  ? ptr_q[i] + 12'h001 :
                 ptr_q[i];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ptr_q[i] <= `AFDA_PTR_RST;
      end else begin
        ptr_q[i] <= nxt;
      end
    end
  end

  // register state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= `AFDA_FLAG_RST;
      bank_q  <= `AFDA_BANK_RST;
      ext_q   <= 1'b0;
      acc_q   <= `AFDA_ACC_RST;
    end else begin
      flags_q <= flags_d;
      bank_q  <= bank_d;
      ext_q   <= ext_d;
      acc_q   <= acc_d;
    end
  end

  // output flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q    <= '0;
      prog_q   <= 20'h00000;
      pload_q  <= 1'b0;
      addr_q   <= 12'h000;
      prdata_q <= 32'h0000_0000;
    end else begin
      res_q   <= res_d;
      pload_q <= fire && op.kind == K_JUMP;
      if (fire && op.kind == K_JUMP) begin
        prog_q <= op.prog;
      end
      if (fire) begin
        addr_q <= tgt_addr;
      end
      if (psel && !penable) begin
        prdata_q <= prdata_d;
      end
    end
  end

  assign res       = res_q;
  assign prog_addr = prog_q;
  assign prog_load = pload_q;
  assign op_addr   = addr_q;

  // checks
  a_clear_sets_zero: assert property (@(posedge pclk) disable iff (!presetn)
    fire && op.kind == K_CLR |=> flags_q[`AFDA_Z_BIT]
      && flags_q[4:3] == $past(flags_q[4:3]) && flags_q[1:0] == $past(flags_q[1:0]))
    else $error("clear did not leave only zero set");
  a_flag_write_block: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fl && aff == 5'h1f && !wr_en |=> flags_q == $past(calc))
    else $error("file write reached op-owned flags");
  a_neg_follows: assert property (@(posedge pclk) disable iff (!presetn)
    is_fw && aff[`AFDA_N_BIT] |=> flags_q[`AFDA_N_BIT] == res_q.data[7])
    else $error("negative flag mismatch");
  a_zero_follows: assert property (@(posedge pclk) disable iff (!presetn)
    is_fw && aff[`AFDA_Z_BIT] |=> flags_q[`AFDA_Z_BIT] == (res_q.data == 8'h00))
    else $error("zero flag mismatch");
  a_carry_add: assert property (@(posedge pclk) disable iff (!presetn)
    fire && op.kind == K_ADD |=> flags_q[`AFDA_C_BIT] == $past(sum9[8]))
    else $error("carry not from bit 7");
  a_flags_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !fire && !(wr_en && hit_fl) |=> $stable(flags_q))
    else $error("flags changed without cause");
  a_bank_direct: assert property (@(posedge pclk) disable iff (!presetn)
    fire && op.amode == AM_DIRECT && op.acc_a |=> op_addr == {$past(bank_q), $past(op.faddr)})
    else $error("banked address wrong");
  a_full_addr: assert property (@(posedge pclk) disable iff (!presetn)
    fire && op.amode == AM_FULL |=> op_addr == $past(op.full))
    else $error("full address altered");
  a_ptr_after_bump_up_operand: assert property (@(posedge pclk) disable iff (!presetn)
    fire && op.amode == AM_POINTER && op.pact == PA_AFTER_BUMP_UP_OPERAND && op.psel == 2'd0 && !wr_en
      |=> ptr_q[0] == $past(ptr_q[0]) + 12'h001 ##1 1'b1)
    else $error("post increment lost");
  a_accum_offset_operand_hold: assert property (@(posedge pclk) disable iff (!presetn)
    fire && op.amode == AM_POINTER && op.pact == PA_ACCUM_OFFSET_OPERAND && !wr_en
      |=> $stable(ptr_q[0]) && $stable(ptr_q[1]) && $stable(ptr_q[2]))
    else $error("offset access moved a pointer");
  a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && hit_fl |=> prdata[31:5] == 27'h0000000)
    else $error("upper flag bits not zero");

  // flag checks restate each flag from the carries; the overflow check still reads the adder wire sum9
  a_ovf_signed: assert property (@(posedge pclk) disable iff (!presetn)
    fire && (op.kind == K_ADD || op.kind == K_SUB)
      |=> flags_q[`AFDA_OV_BIT] == $past(sum9[8] ^ opa[7] ^ opb[7] ^ sum9[7]))
    else $error("overflow flag mismatch");
  a_half_carry: assert property (@(posedge pclk) disable iff (!presetn)
    fire && op.kind == K_ADD |=> flags_q[`AFDA_DC_BIT] == $past(({1'b0, opa[3:0]} + {1'b0, acc_q[3:0]}) > 5'h0f))
    else $error("half byte carry mismatch");
  a_sub_borrow: assert property (@(posedge pclk) disable iff (!presetn)
    fire && op.kind == K_SUB |=> flags_q[`AFDA_C_BIT] == $past(opa >= acc_q))
    else $error("borrow polarity wrong");
  a_rot_right: assert property (@(posedge pclk) disable iff (!presetn)
    fire && op.kind == K_ROTR |=> flags_q[`AFDA_C_BIT] == $past(fopnd[0])
      && flags_q[`AFDA_DC_BIT] == $past(fopnd[4]))
    else $error("right rotate carries wrong");
  a_rot_left: assert property (@(posedge pclk) disable iff (!presetn)
    fire && op.kind == K_ROTL |=> flags_q[`AFDA_C_BIT] == $past(fopnd[7])
      && flags_q[`AFDA_DC_BIT] == $past(fopnd[3]))
    else $error("left rotate carries wrong");
  a_jump_target: assert property (@(posedge pclk) disable iff (!presetn)
    fire && op.kind == K_JUMP |=> prog_load && prog_addr == $past(op.prog))
    else $error("jump target not loaded");
  a_access_bank: assert property (@(posedge pclk) disable iff (!presetn)
    fire && op.amode == AM_DIRECT && !op.acc_a && !ext_q
      |=> op_addr == {($past(op.faddr) >= `AFDA_ACC_SPLIT) ? `AFDA_SFR_PAGE : `AFDA_LOW_PAGE, $past(op.faddr)})
    else $error("access bank address wrong");
  a_dest_select: assert property (@(posedge pclk) disable iff (!presetn)
    fire && op.kind != K_JUMP && op.has_d |=> res.to_w == !$past(op.dest_d))
    else $error("destination bit ignored");
  a_implicit_dest: assert property (@(posedge pclk) disable iff (!presetn)
    fire && op.kind != K_JUMP && !op.has_d |=> res.to_w == $past(op.use_lit))
    else $error("implicit destination wrong");
  a_ptr_after_bump_down_operand: assert property (@(posedge pclk) disable iff (!presetn)
    fire && op.amode == AM_POINTER && op.pact == PA_AFTER_BUMP_DOWN_OPERAND && op.psel == 2'd0 && !wr_en
      |=> ptr_q[0] == $past(ptr_q[0]) - 12'h001)
    else $error("post decrement lost");
  a_ptr_target: assert property (@(posedge pclk) disable iff (!presetn)
    fire && op.amode == AM_POINTER && (op.pact == PA_AFTER_BUMP_UP_OPERAND || op.pact == PA_AFTER_BUMP_DOWN_OPERAND)
      |=> op_addr == $past(ptr_q[op.psel]))
    else $error("pointer target altered");
  a_idx_offset: assert property (@(posedge pclk) disable iff (!presetn)
    fire && op.amode == AM_DIRECT && !op.acc_a && ext_q && op.faddr <= `AFDA_IDX_LIMIT
      |=> op_addr == $past(ptr_q[2]) + {4'h0, $past(op.faddr)})
    else $error("literal offset address wrong");

  c_sub_op:   cover property (@(posedge pclk) disable iff (!presetn) fire && op.kind == K_SUB);
  c_rot_op:   cover property (@(posedge pclk) disable iff (!presetn) fire && op.kind == K_ROTL);
  c_idx_mode: cover property (@(posedge pclk) disable iff (!presetn) fire && idx_mode);
  c_flag_dst: cover property (@(posedge pclk) disable iff (!presetn) wr_fl);
  c_ptr_op:   cover property (@(posedge pclk) disable iff (!presetn) fire && op.amode == AM_POINTER);
endmodule : afda_core

/* File: bench/afda_mem_model.sv */
// data memory model facing the core's file operand port
// assumes: bench gives the operand address with each op
`timescale 1ns/10ps
module afda_mem_model
  import afda_pkg::*;
(
  // clock
  input  wire logic         pclk,
  // read side
  input  wire logic         op_valid,
  input  wire logic [11:0]  rd_addr,
  output logic [7:0]        mem_rdata,
  // write side
  input  wire afda_res_type res
);
  logic [7:0] mem [4096];
  logic [7:0] junk_q = 8'h3c;
  // preload a pattern the bench can predict
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'ha5;
  end
  // file writes land on the edge the result shows
  always @(posedge pclk) begin
    junk_q <= ~junk_q;
    if (res.valid && res.to_file) mem[res.addr] <= res.data;
  end
  // idle bus toggles so stale data never passes for an answer
  assign mem_rdata = op_valid ? mem[rd_addr] : junk_q;
endmodule : afda_mem_model

/* File: bench/alu_flags_and_data_addressing_bench.sv */
// self-checking bench of the flag and addressing core
// assumes: apb answers with no wait states, ops answer next edge
`timescale 1ns/10ps
`include "afda_params.svh"
module alu_flags_and_data_addressing_bench;
  import afda_pkg::*;
  localparam logic [32:0] NONE = 33'h100000000;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic         op_valid, prog_load;
  logic [31:0]  paddr, pwdata, prdata;
  logic [7:0]   mem_rdata, w;
  logic [11:0]  rd_addr, op_addr;
  logic [19:0]  prog_addr;
  logic [4:0]   f;
  afda_op_type  op_r;
  afda_res_type res;
  logic [32:0]  rd_q[$], res_q[$], prog_q[$];
  int           err_total, checks_done, cyc;

  afda_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_valid(op_valid), .op(op_r), .mem_rdata(mem_rdata), .res(res), .prog_addr(prog_addr),
    .prog_load(prog_load), .op_addr(op_addr));
  afda_mem_model mem_i (.pclk(pclk), .op_valid(op_valid), .rd_addr(rd_addr), .mem_rdata(mem_rdata), .res(res));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  task report_and_stop;
    if (err_total == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // watcher: oldest note against each result that shows
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) chk("prdata", rd_q.size() ? rd_q.pop_front() : NONE, {pslverr, prdata});
    if (res.valid) begin
      chk("op_addr", res_q.size() ? {21'h0, res_q[0][21:10]} : NONE, {21'h0, op_addr});
      chk("result", res_q.size() ? res_q.pop_front() : NONE,
          {res.addr, res.data, res.to_w, res.to_file});
    end
    if (prog_load) chk("prog_addr", prog_q.size() ? prog_q.pop_front() : NONE, prog_addr);
  end

  // hang guard, far above the few hundred cycles used
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {20'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic flags;
    rd(`AFDA_FLAG_OFS, {28'h0, f});
  endtask : flags

  task automatic drive(input afda_op_type o, input logic [11:0] ea);
    @(posedge pclk);
    op_valid <= 1'b1;
    op_r <= o;
    rd_addr <= ea;
    @(posedge pclk);
    op_valid <= 1'b0;
  endtask : drive

  function automatic afda_op_type mk(afda_kind_type k, afda_amode_type m, afda_pact_type p, logic [7:0] fa,
                                     logic aa, logic hd, logic dd, logic ul, logic [7:0] l);
    mk = '{k, m, p, 2'd0, fa, aa, hd, dd, ul, l, 12'h0, 20'h0};
  endfunction : mk

  // expected result, flags and destination worked out here
  task automatic run(input afda_op_type o, input logic [11:0] ea);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] a, b, r;
    logic       tw, tf;
    a = o.use_lit ? o.lit : (ea == `AFDA_FLAG_OFS ? {3'b0, f} : ea[7:0] ^ 8'ha5);
    b = (o.kind == K_SUB) ? ~w : w;
    s = {1'b0, a} + {1'b0, b} + (o.kind == K_SUB);
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + (o.kind == K_SUB);
    case (o.kind)
      K_ADD, K_SUB: begin
        r = s[7:0];
        f = {r[7], a[7] == b[7] && r[7] != a[7], r == 8'h00, h[4], s[8]};
      end
      K_AND, K_OR, K_XOR: begin
        r = o.kind == K_AND ? a & w : (o.kind == K_OR ? a | w : a ^ w);
        f[4] = r[7];
        f[2] = (r == 8'h00);
      end
      K_ROTR: begin
        r = {f[0], a[7:1]};
        f = {r[7], f[3], r == 8'h00, a[4], a[0]};
      end
      K_ROTL: begin
        r = {a[6:0], f[0]};
        f = {r[7], f[3], r == 8'h00, a[3], a[7]};
      end
      K_SWAP:   r = {a[3:0], a[7:4]};
      K_BITSET: r = a | (8'h01 << o.lit[2:0]);
      K_BITCLR: r = a & ~(8'h01 << o.lit[2:0]);
      K_MOVW:   r = w;
      default: begin
        r = 8'h00;
        f[2] = 1'b1;
      end
    endcase
    tw = o.has_d ? !o.dest_d : o.use_lit;
    tf = (o.has_d ? o.dest_d : !o.use_lit) && ea != `AFDA_FLAG_OFS;
    if (tw) w = r;
    // only flag-neutral ops may load the flag register from their result
    if (!tw && ea == `AFDA_FLAG_OFS && (o.kind == K_MOVW || o.kind == K_BITCLR || o.kind == K_BITSET ||
        o.kind == K_SWAP)) f = r[4:0];
    res_q.push_back({ea, r, tw, tf});
    drive(o, ea);
  endtask : run

  initial begin
    afda_op_type o;
    logic [7:0]  v;
    logic [11:0] ea_t[4], pt_t[4];
    afda_pact_type pa_t[4];
    {presetn, psel, penable, pwrite, op_valid} = 5'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    op_r = '0;
    rd_addr = 12'h0;
    f = 5'h00;
    w = 8'h00;
    void'($urandom(32'h2b6c));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    flags();
    rd(`AFDA_ACC_OFS, 33'h0);
    rd(12'h004, NONE);
    apb(1'b1, `AFDA_FLAG_OFS, 32'hff); // flags preset without any flag-setting op
    f = 5'h1f;
    flags();
    // add and subtract, sign boundary first, then random
    for (int i = 0; i < 12; i++) begin
      w = i < 2 ? 8'h80 : 8'($urandom);
      apb(1'b1, `AFDA_ACC_OFS, {24'h0, w});
      v = i < 2 ? 8'h80 : 8'($urandom);
      run(mk(i[0] ? K_SUB : K_ADD, AM_DIRECT, PA_PLAIN, 8'h0, 1'b0, 1'b0, 1'b0, 1'b1, v), 12'h0);
      flags();
    end
    // rotates and logic on low access bank operands
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom_range(95));
      o = mk(i < 2 ? K_ROTR : i < 4 ? K_ROTL : i < 6 ? K_AND : i == 6 ? K_OR : K_XOR,
             AM_DIRECT, PA_PLAIN, v, 1'b0, 1'b1, 1'b0, 1'b0, 8'h0);
      run(o, {4'h0, v});
      flags();
    end
    // clear and add aimed at the flag register
    apb(1'b1, `AFDA_FLAG_OFS, 32'h1b);
    f = 5'h1b;
    run(mk(K_CLR, AM_DIRECT, PA_PLAIN, 8'hd8, 1'b0, 1'b0, 1'b0, 1'b0, 8'h0), `AFDA_FLAG_OFS);
    flags();
    run(mk(K_ADD, AM_DIRECT, PA_PLAIN, 8'hd8, 1'b0, 1'b1, 1'b1, 1'b0, 8'h0), `AFDA_FLAG_OFS);
    flags();
    // banked, upper access bank and full address forms
    apb(1'b1, `AFDA_BANK_OFS, 32'h3);
    v = 8'($urandom);
    run(mk(K_ADD, AM_DIRECT, PA_PLAIN, v, 1'b1, 1'b1, 1'b1, 1'b0, 8'h0), {4'h3, v});
    run(mk(K_ADD, AM_DIRECT, PA_PLAIN, 8'h80, 1'b0, 1'b1, 1'b0, 1'b0, 8'h0), 12'hf80);
    o = mk(K_ADD, AM_FULL, PA_PLAIN, 8'h11, 1'b1, 1'b1, 1'b0, 1'b0, 8'h0);
    o.full = 12'h456;
    run(o, 12'h456);
    // literal offset only with the extended set on
    apb(1'b1, `AFDA_CTRL_OFS, 32'h1);
    apb(1'b1, `AFDA_PTR2_OFS, 32'h123);
    run(mk(K_ADD, AM_DIRECT, PA_PLAIN, 8'h5f, 1'b0, 1'b1, 1'b0, 1'b0, 8'h0), 12'h182);
    run(mk(K_ADD, AM_DIRECT, PA_PLAIN, 8'h60, 1'b0, 1'b1, 1'b0, 1'b0, 8'h0), 12'hf60);
    apb(1'b1, `AFDA_CTRL_OFS, 32'h0);
    // pointer operands across the low byte wrap, bank still set
    apb(1'b1, `AFDA_PTR0_OFS, 32'h0ff);
    pa_t = '{PA_AFTER_BUMP_UP_OPERAND, PA_AFTER_BUMP_DOWN_OPERAND, PA_BEFORE_BUMP_UP_OPERAND, PA_ACCUM_OFFSET_OPERAND};
    ea_t = '{12'h0ff, 12'h100, 12'h100, 12'h080};
    pt_t = '{12'h100, 12'h0ff, 12'h100, 12'h100};
    for (int i = 0; i < 4; i++) begin
      if (i == 3) begin
        w = 8'h80;
        apb(1'b1, `AFDA_ACC_OFS, 32'h80);
      end
      run(mk(K_ADD, AM_POINTER, pa_t[i], 8'h42, 1'b1, 1'b1, 1'b0, 1'b0, 8'h0), ea_t[i]);
      rd(`AFDA_PTR0_OFS, {21'h0, pt_t[i]});
    end
    // flag-neutral ops aimed at the flag register load it unmasked
    for (int i = 0; i < 4; i++) begin
      o = mk(i == 0 ? K_SWAP : i == 1 ? K_BITSET : i == 2 ? K_BITCLR : K_MOVW, AM_DIRECT, PA_PLAIN, 8'hd8,
             1'b0, i == 0, 1'b1, 1'b0, 8'($urandom_range(4)));
      run(o, `AFDA_FLAG_OFS);
      flags();
    end
    // jump target literal
    o = mk(K_JUMP, AM_DIRECT, PA_PLAIN, 8'h0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h0);
    o.prog = 20'($urandom);
    prog_q.push_back(o.prog);
    drive(o, 12'h0);
    repeat (4) @(posedge pclk);
    chk("pending", 33'h0, rd_q.size() + res_q.size() + prog_q.size());
    report_and_stop();
  end
endmodule : alu_flags_and_data_addressing_bench
